// ---- pkg/dgp_regs.svh ----
// Register offsets, field positions and reset values of the dual GPIO port.
`ifndef DGP_REGS_SVH
`define DGP_REGS_SVH

`define DGP_OFS_H_DIR        8'h00
`define DGP_OFS_H_PIN        8'h04
`define DGP_OFS_H_LAT        8'h08
`define DGP_OFS_ANA_CFG      8'h0C
`define DGP_OFS_MEM_CFG      8'h10
`define DGP_OFS_J_DIR        8'h14
`define DGP_OFS_J_PIN        8'h18
`define DGP_OFS_J_LAT        8'h1C
`define DGP_OFS_PWM_MAP      8'h20

`define DGP_RST_DIR          8'hFF
`define DGP_RST_LAT          8'h00
`define DGP_RST_ANA_CFG      8'h00
`define DGP_RST_MEM_CFG      8'h00
`define DGP_RST_PWM_MAP      1'h0

`define DGP_ANA_CFG_MASK     8'h3F
`define DGP_MEM_CFG_MASK     8'hB3
`define DGP_MEM_BUS_OFF_BIT  7
`define DGP_MEM_WAIT_HI      5
`define DGP_MEM_WAIT_LO      4
`define DGP_MEM_MODE_HI      1
`define DGP_MEM_MODE_LO      0
`define DGP_ANA_VREF_HI      5
`define DGP_ANA_VREF_LO      4
`define DGP_ANA_PCFG_HI      3
`define DGP_ANA_PCFG_LO      0
`define DGP_ANA_FIRST_CHAN   4'hC
`define DGP_J_STROBE_MASK    8'hDF

`define DGP_RESP_OKAY        2'h0
`define DGP_RESP_SLVERR      2'h2

`endif

// ---- pkg/dgp_pkg.sv ----
// Types shared by the dual GPIO port design and its bench.
package dgp_pkg;

  typedef enum logic [1:0] {
    WR_IDLE     = 2'h0,
    WR_GOT_ADDR = 2'h1,
    WR_RESP     = 2'h3,
    WR_GOT_DATA = 2'h2
  } dgp_wr_state_t;

  typedef struct packed {
    logic upper_byte_select;
    logic lower_byte_select;
    logic byte_addr0;
    logic write_high_strobe;
    logic write_low_strobe;
    logic output_enable;
    logic addr_latch_enable;
  } dgp_ext_strobe_t;

  typedef struct packed {
    logic [7:0] level;
    logic [7:0] enable;
  } dgp_pin_drive_t;

endpackage

// ---- rtl/dgp_port.sv ----
// Dual 8-bit GPIO port with analog, memory bus and PWM pin sharing.
//
// Summary of operation
// - First port direction bit 1 turns that pin's driver off.
// - First port direction bit 0 drives the output latch bit.
// - First port latch register reads return the latch, not the pins.
// - First port has eight pins, each with direction, latch and read bit.
// - Upper four first port pins are digital or analog channels 12 to 15.
// - Lower four first port pins carry address bits 16-19 or are GPIO.
// - After reset upper nibble is analog and reads back as zero.
// - After reset lower nibble carries the external address bits.
// - Lower nibble samples Schmitt in GPIO mode, TTL in bus or slave mode.
// - Four PWM outputs use the upper nibble only while remap is clear.
// - Second port direction 1 tri-states, 0 drives the latch bit.
// - Second port latch register reads return the latch contents.
// - Second port bits other than 5 are GPIO only with bus disabled; bus mode drives strobes.
// - Second port bit 5 is never taken by the external bus.
// - A peripheral may force a second port pin to output or input.
// - Peripheral forcing never alters the readable direction register.
// - After reset only second port bit 5 is a digital input; the bus drives the other seven.
// - Bus mode maps strobes onto second port bits 0-4, 6 and 7.
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.

`timescale 1ns/1ps
`include "dgp_regs.svh"

module dgp_port (
  input  wire logic                     CORE_CLK,
  input  wire logic                     RESET_N,
  input  wire logic [7:0]               AWADDR,
  input  wire logic [2:0]               AWPROT,
  input  wire logic                     AWVALID,
  output logic                          AWREADY,
  input  wire logic [31:0]              WDATA,
  input  wire logic [3:0]               WSTRB,
  input  wire logic                     WVALID,
  output logic                          WREADY,
  output logic [1:0]                    BRESP,
  output logic                          BVALID,
  input  wire logic                     BREADY,
  input  wire logic [7:0]               ARADDR,
  input  wire logic [2:0]               ARPROT,
  input  wire logic                     ARVALID,
  output logic                          ARREADY,
  output logic [31:0]                   RDATA,
  output logic [1:0]                    RRESP,
  output logic                          RVALID,
  input  wire logic                     RREADY,
  input  wire logic [7:0]               H_PIN_IN,
  output logic [7:0]                    H_PIN_OUT,
  output logic [7:0]                    H_PIN_OE,
  output logic                          H_LO_TTL_SEL,
  output logic [3:0]                    ANALOG_CHAN_SEL,
  output logic [1:0]                    ANALOG_VREF_CFG,
  output logic                          EXT_BUS_EN,
  output logic [1:0]                    EXT_WAIT_CFG,
  output logic [1:0]                    EXT_WRITE_MODE,
  input  wire logic [3:0]               EXT_ADDR_HIGH_BITS,
  input  wire dgp_pkg::dgp_ext_strobe_t EXT_STROBE,
  input  wire logic                     PSP_MODE,
  input  wire logic [3:0]               PWM_OUT,
  input  wire logic [3:0]               PWM_EN,
  output logic                          PWM_PIN_REMAP,
  input  wire logic [7:0]               J_PIN_IN,
  output logic [7:0]                    J_PIN_OUT,
  output logic [7:0]                    J_PIN_OE,
  input  wire logic [7:0]               J_FORCE_OUT,
  input  wire logic [7:0]               J_FORCE_IN,
  input  wire logic [7:0]               J_PERIPH_DATA
);

  ////////////////////////////////////////////////////////////////////////////

  logic [7:0]              port_h_direction_q;
  logic [7:0]              port_h_output_latch_q;
  logic [7:0]              analog_pin_config_q;
  logic [7:0]              memory_bus_config_q;
  logic [7:0]              port_j_direction_q;
  logic [7:0]              port_j_output_latch_q;
  logic                    pwm_pin_remap_q;
  logic [7:0]              h_sample_q;
  logic [7:0]              j_sample_q;
  logic [3:0]              h_analog;
  logic                    bus_mode;
  logic [7:0]              j_strobe_vec;
  dgp_pkg::dgp_pin_drive_t h_drive_d;
  dgp_pkg::dgp_pin_drive_t h_drive_q;
  dgp_pkg::dgp_pin_drive_t j_drive_d;
  dgp_pkg::dgp_pin_drive_t j_drive_q;
  dgp_pkg::dgp_wr_state_t  wr_state_q;
  logic [7:0]              aw_addr_q;
  logic [7:0]              w_data_q;
  logic                    w_lane0_q;
  logic                    wr_fire;
  logic                    wr_hit;
  logic [1:0]              bresp_q;
  logic [31:0]             rdata_d;
  logic [31:0]             rdata_q;
  logic [1:0]              rresp_d;
  logic [1:0]              rresp_q;
  logic                    rvalid_q;
  localparam logic [7:0]   j_strobe_mask = `DGP_J_STROBE_MASK;

  ////////////////////////////////////////////////////////////////////////////

  // The external bus owns its pins while the disable bit is clear.
  assign bus_mode = ~memory_bus_config_q[`DGP_MEM_BUS_OFF_BIT];

  // A higher setting turns more of channels 12 to 15 into digital pins.
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      h_analog[k] = (analog_pin_config_q[`DGP_ANA_PCFG_HI:`DGP_ANA_PCFG_LO]
                     <= 4'(3 - k));
    end
  end

  assign j_strobe_vec = {EXT_STROBE.upper_byte_select,
                         EXT_STROBE.lower_byte_select,
                         1'b0,
                         EXT_STROBE.byte_addr0,
                         EXT_STROBE.write_high_strobe,
                         EXT_STROBE.write_low_strobe,
                         EXT_STROBE.output_enable,
                         EXT_STROBE.addr_latch_enable};

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers, one slice per bit.

  for (genvar i = 0; i < 8; i++) begin : g_pin
    if (i < 4) begin : g_h_lo
      always_comb begin
        if (bus_mode) begin
          h_drive_d.level[i]  = EXT_ADDR_HIGH_BITS[i];
          h_drive_d.enable[i] = 1'b1;
        end else begin
          h_drive_d.level[i]  = port_h_output_latch_q[i];
          h_drive_d.enable[i] = ~port_h_direction_q[i];
        end
      end
    end else begin : g_h_hi
      always_comb begin
        if (PWM_EN[i-4] && !pwm_pin_remap_q) begin
          h_drive_d.level[i]  = PWM_OUT[i-4];
          h_drive_d.enable[i] = 1'b1;
        end else if (h_analog[i-4]) begin
          h_drive_d.level[i]  = 1'b0;
          h_drive_d.enable[i] = 1'b0;
        end else begin
          h_drive_d.level[i]  = port_h_output_latch_q[i];
          h_drive_d.enable[i] = ~port_h_direction_q[i];
        end
      end
    end

    // Forcing acts on the driver only, so software keeps its own setting.
    always_comb begin
      if (bus_mode && j_strobe_mask[i]) begin
        j_drive_d.level[i]  = j_strobe_vec[i];
        j_drive_d.enable[i] = 1'b1;
      end else if (J_FORCE_OUT[i]) begin
        j_drive_d.level[i]  = J_PERIPH_DATA[i];
        j_drive_d.enable[i] = 1'b1;
      end else if (J_FORCE_IN[i]) begin
        j_drive_d.level[i]  = port_j_output_latch_q[i];
        j_drive_d.enable[i] = 1'b0;
      end else begin
        j_drive_d.level[i]  = port_j_output_latch_q[i];
        j_drive_d.enable[i] = ~port_j_direction_q[i];
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      h_drive_q <= '0;
      j_drive_q <= '0;
    end else begin
      h_drive_q <= h_drive_d;
      j_drive_q <= j_drive_d;
    end
  end

  assign H_PIN_OUT = h_drive_q.level;
  assign H_PIN_OE  = h_drive_q.enable;
  assign J_PIN_OUT = j_drive_q.level;
  assign J_PIN_OE  = j_drive_q.enable;

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling; analog pins read as zero on the digital path.

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      h_sample_q <= '0;
      j_sample_q <= '0;
    end else begin
      h_sample_q <= {H_PIN_IN[7:4] & ~h_analog, H_PIN_IN[3:0]};
      j_sample_q <= J_PIN_IN;
    end
  end

  // The threshold is chosen by the pad; the block only tells it which.
  assign H_LO_TTL_SEL = bus_mode | PSP_MODE;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration outputs.

  assign ANALOG_CHAN_SEL = h_analog;
  assign ANALOG_VREF_CFG =
    analog_pin_config_q[`DGP_ANA_VREF_HI:`DGP_ANA_VREF_LO];
  assign EXT_BUS_EN      = bus_mode;
  assign EXT_WAIT_CFG    =
    memory_bus_config_q[`DGP_MEM_WAIT_HI:`DGP_MEM_WAIT_LO];
  assign EXT_WRITE_MODE  =
    memory_bus_config_q[`DGP_MEM_MODE_HI:`DGP_MEM_MODE_LO];
  assign PWM_PIN_REMAP   = pwm_pin_remap_q;

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data may arrive in either order.

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      wr_state_q <= dgp_pkg::WR_IDLE;
    end else begin
      case (wr_state_q)
        dgp_pkg::WR_IDLE: begin
          if (AWVALID && WVALID) begin
            wr_state_q <= dgp_pkg::WR_RESP;
          end else if (AWVALID) begin
            wr_state_q <= dgp_pkg::WR_GOT_ADDR;
          end else if (WVALID) begin
            wr_state_q <= dgp_pkg::WR_GOT_DATA;
          end
        end
        dgp_pkg::WR_GOT_ADDR: begin
          if (WVALID) begin
            wr_state_q <= dgp_pkg::WR_RESP;
          end
        end
        dgp_pkg::WR_GOT_DATA: begin
          if (AWVALID) begin
            wr_state_q <= dgp_pkg::WR_RESP;
          end
        end
        dgp_pkg::WR_RESP: begin
          if (BREADY) begin
            wr_state_q <= dgp_pkg::WR_IDLE;
          end
        end
        default: begin
          wr_state_q <= dgp_pkg::WR_IDLE;
        end
      endcase
    end
  end

  assign AWREADY = (wr_state_q == dgp_pkg::WR_IDLE) ||
                   (wr_state_q == dgp_pkg::WR_GOT_DATA);
  assign WREADY  = (wr_state_q == dgp_pkg::WR_IDLE) ||
                   (wr_state_q == dgp_pkg::WR_GOT_ADDR);
  assign BVALID  = (wr_state_q == dgp_pkg::WR_RESP);
  assign BRESP   = bresp_q;

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_lane0_q <= 1'b0;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_addr_q <= AWADDR;
      end
      if (WVALID && WREADY) begin
        w_data_q  <= WDATA[7:0];
        w_lane0_q <= WSTRB[0];
      end
    end
  end

  // The register update happens in the cycle the response is raised.
  assign wr_fire = (wr_state_q != dgp_pkg::WR_RESP) &&
                   (wr_state_q != dgp_pkg::WR_IDLE) &&
                   ((wr_state_q == dgp_pkg::WR_GOT_ADDR) ? WVALID : AWVALID)
                   || ((wr_state_q == dgp_pkg::WR_IDLE) && AWVALID && WVALID);

  logic [7:0] wr_addr;
  logic [7:0] wr_byte;
  logic       wr_lane0;
  assign wr_addr  = (AWVALID && AWREADY) ? AWADDR : aw_addr_q;
  assign wr_byte  = (WVALID && WREADY) ? WDATA[7:0] : w_data_q;
  assign wr_lane0 = (WVALID && WREADY) ? WSTRB[0] : w_lane0_q;

  always_comb begin
    case (wr_addr)
      `DGP_OFS_H_DIR, `DGP_OFS_H_PIN, `DGP_OFS_H_LAT, `DGP_OFS_ANA_CFG,
      `DGP_OFS_MEM_CFG, `DGP_OFS_J_DIR, `DGP_OFS_J_PIN, `DGP_OFS_J_LAT,
      `DGP_OFS_PWM_MAP: wr_hit = 1'b1;
      default:          wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      bresp_q <= `DGP_RESP_OKAY;
    end else if (wr_fire) begin
      bresp_q <= wr_hit ? `DGP_RESP_OKAY : `DGP_RESP_SLVERR;
    end
  end

  logic wr_go;
  assign wr_go = wr_fire && wr_lane0;

  ////////////////////////////////////////////////////////////////////////////
  // Register store, one process per register.

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      port_h_direction_q <= `DGP_RST_DIR;
    end else if (wr_go && wr_addr == `DGP_OFS_H_DIR) begin
      port_h_direction_q <= wr_byte;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      port_h_output_latch_q <= `DGP_RST_LAT;
    end else if (wr_go && (wr_addr == `DGP_OFS_H_LAT ||
                           wr_addr == `DGP_OFS_H_PIN)) begin
      port_h_output_latch_q <= wr_byte;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      analog_pin_config_q <= `DGP_RST_ANA_CFG;
    end else if (wr_go && wr_addr == `DGP_OFS_ANA_CFG) begin
      analog_pin_config_q <= wr_byte & `DGP_ANA_CFG_MASK;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      memory_bus_config_q <= `DGP_RST_MEM_CFG;
    end else if (wr_go && wr_addr == `DGP_OFS_MEM_CFG) begin
      memory_bus_config_q <= wr_byte & `DGP_MEM_CFG_MASK;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      port_j_direction_q <= `DGP_RST_DIR;
    end else if (wr_go && wr_addr == `DGP_OFS_J_DIR) begin
      port_j_direction_q <= wr_byte;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      port_j_output_latch_q <= `DGP_RST_LAT;
    end else if (wr_go && (wr_addr == `DGP_OFS_J_LAT ||
                           wr_addr == `DGP_OFS_J_PIN)) begin
      port_j_output_latch_q <= wr_byte;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      pwm_pin_remap_q <= `DGP_RST_PWM_MAP;
    end else if (wr_go && wr_addr == `DGP_OFS_PWM_MAP) begin
      pwm_pin_remap_q <= wr_byte[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: one read at a time, answered one cycle after the address.

  always_comb begin
    rdata_d = '0;
    rresp_d = `DGP_RESP_OKAY;
    case (ARADDR)
      `DGP_OFS_H_DIR:   rdata_d[7:0] = port_h_direction_q;
      `DGP_OFS_H_PIN:   rdata_d[7:0] = h_sample_q;
      `DGP_OFS_H_LAT:   rdata_d[7:0] = port_h_output_latch_q;
      `DGP_OFS_ANA_CFG: rdata_d[7:0] = analog_pin_config_q;
      `DGP_OFS_MEM_CFG: rdata_d[7:0] = memory_bus_config_q;
      `DGP_OFS_J_DIR:   rdata_d[7:0] = port_j_direction_q;
      `DGP_OFS_J_PIN:   rdata_d[7:0] = j_sample_q;
      `DGP_OFS_J_LAT:   rdata_d[7:0] = port_j_output_latch_q;
      `DGP_OFS_PWM_MAP: rdata_d[0]   = pwm_pin_remap_q;
      default:          rresp_d      = `DGP_RESP_SLVERR;
    endcase
  end

  assign ARREADY = ~rvalid_q;

  always_ff @(posedge CORE_CLK) begin
    if (!RESET_N) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= `DGP_RESP_OKAY;
    end else if (ARVALID && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rdata_d;
      rresp_q  <= rresp_d;
    end else if (rvalid_q && RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  assign RVALID = rvalid_q;
  assign RDATA  = rdata_q;
  assign RRESP  = rresp_q;

endmodule

// ---- test/dgp_port_chk.sv ----
// Concurrent checks on the dual GPIO port pins and register bus.
`timescale 1ns/1ps
module dgp_port_chk (
  input wire logic                     CORE_CLK,
  input wire logic                     RESET_N,
  input wire logic                     AWVALID,
  input wire logic                     AWREADY,
  input wire logic                     WVALID,
  input wire logic                     WREADY,
  input wire logic                     BVALID,
  input wire logic                     BREADY,
  input wire logic                     ARVALID,
  input wire logic                     ARREADY,
  input wire logic                     RVALID,
  input wire logic                     RREADY,
  input wire logic [7:0]               H_PIN_OUT,
  input wire logic [7:0]               H_PIN_OE,
  input wire logic                     H_LO_TTL_SEL,
  input wire logic [3:0]               ANALOG_CHAN_SEL,
  input wire logic                     EXT_BUS_EN,
  input wire logic [3:0]               EXT_ADDR_HIGH_BITS,
  input wire dgp_pkg::dgp_ext_strobe_t EXT_STROBE,
  input wire logic                     PSP_MODE,
  input wire logic [3:0]               PWM_OUT,
  input wire logic [3:0]               PWM_EN,
  input wire logic                     PWM_PIN_REMAP,
  input wire logic [7:0]               J_PIN_OUT,
  input wire logic [7:0]               J_PIN_OE,
  input wire logic [7:0]               J_FORCE_OUT,
  input wire logic [7:0]               J_FORCE_IN,
  input wire logic [7:0]               J_PERIPH_DATA
);
  // Pins lag one cycle, so attempts from the last reset edge are skipped.
  logic       live_q;
  logic [6:0] strb;
  logic [7:0] jmap;
  logic [3:0] pwm_on;
  logic [3:0] an_only;
  always_ff @(posedge CORE_CLK) begin
    live_q <= RESET_N;
  end
  assign strb    = EXT_STROBE;
  assign jmap    = {strb[6:5], 1'b0, strb[4:0]};
  assign pwm_on  = PWM_EN & ~{4{PWM_PIN_REMAP}};
  assign an_only = ANALOG_CHAN_SEL & ~pwm_on;
  default clocking dck @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESET_N || !live_q);
  sequence wr_both;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence
  sequence rd_take;
    ARVALID && ARREADY;
  endsequence
  //////////////////////////////////////////////////////////////////////////////
  h_bus_addr_a: assert property (
    EXT_BUS_EN |=> H_PIN_OE[3:0] == 4'hF
      && H_PIN_OUT[3:0] == $past(EXT_ADDR_HIGH_BITS))
    else $error("address nibble missing on first port");
  j_strobe_map_a: assert property (
    EXT_BUS_EN |=> (J_PIN_OE & 8'hDF) == 8'hDF
      && (J_PIN_OUT & 8'hDF) == $past(jmap))
    else $error("strobes misplaced on second port");
  analog_off_a: assert property (
    1'b1 |=> (H_PIN_OE[7:4] & $past(an_only)) == 4'h0)
    else $error("analog pin driven");
  pwm_drive_a: assert property (
    pwm_on != 4'h0 |=> (H_PIN_OE[7:4] & $past(pwm_on)) == $past(pwm_on)
      && ((H_PIN_OUT[7:4] ^ $past(PWM_OUT)) & $past(pwm_on)) == 4'h0)
    else $error("pwm output not on upper pins");
  force_out_a: assert property (
    J_FORCE_OUT[5] |=> J_PIN_OE[5] && J_PIN_OUT[5] == $past(J_PERIPH_DATA[5]))
    else $error("forced output ignored");
  force_in_a: assert property (
    J_FORCE_IN[5] && !J_FORCE_OUT[5] |=> !J_PIN_OE[5])
    else $error("forced input ignored");
  ttl_sel_a: assert property (
    H_LO_TTL_SEL == (EXT_BUS_EN || PSP_MODE))
    else $error("input threshold select wrong");
  wr_answer_a: assert property (wr_both |=> BVALID)
    else $error("write response late");
  b_hold_a: assert property (BVALID && !BREADY |=> BVALID)
    else $error("write response dropped");
  b_block_a: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write taken during response");
  rd_answer_a: assert property (rd_take |=> RVALID ##0 !ARREADY)
    else $error("read data late");
  r_hold_a: assert property (RVALID && !RREADY |=> RVALID)
    else $error("read data dropped");
endmodule

bind dgp_port dgp_port_chk dgp_port_chk_inst (.*);

// ---- test/dgp_board_model.sv ----
// Board-side model of both ports: far-side drivers and unpulled nets.
`timescale 1ns/1ps
module dgp_board_model (
  input  wire logic [1:0][7:0] out,
  input  wire logic [1:0][7:0] oe,
  input  wire logic [1:0][7:0] ext,
  input  wire logic [1:0][7:0] ext_en,
  input  wire logic            clk,
  output logic      [1:0][7:0] pin
);
  // No pull exists, so an undriven net wanders rather than keeping a value.
  logic [7:0] float_q = 8'h55;
  always_ff @(posedge clk) begin
    float_q <= ~float_q;
  end
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      for (int b = 0; b < 8; b++) begin
        if (oe[p][b] && ext_en[p][b]) pin[p][b] = 1'bx;
        else if (oe[p][b]) pin[p][b] = out[p][b];
        else if (ext_en[p][b]) pin[p][b] = ext[p][b];
        else pin[p][b] = float_q[b];
      end
    end
  end
endmodule

// ---- test/dgp_port_tb.sv ----
// Self-checking bench for the dual GPIO port through its register bus.
`timescale 1ns/1ps
`include "dgp_regs.svh"
module dgp_port_tb;
  logic            CORE_CLK, RESET_N, AWVALID, AWREADY, WVALID, WREADY;
  logic            BVALID, BREADY, ARVALID, ARREADY, RVALID, RREADY;
  logic            H_LO_TTL_SEL, EXT_BUS_EN, PSP_MODE, PWM_PIN_REMAP;
  logic [1:0]      BRESP, RRESP, ANALOG_VREF_CFG, EXT_WAIT_CFG;
  logic [1:0]      EXT_WRITE_MODE, rsp;
  logic [2:0]      AWPROT, ARPROT;
  logic [3:0]      WSTRB, ANALOG_CHAN_SEL, EXT_ADDR_HIGH_BITS, PWM_OUT, PWM_EN;
  logic [7:0]      AWADDR, ARADDR, H_PIN_IN, H_PIN_OUT, H_PIN_OE, J_PIN_IN;
  logic [7:0]      J_PIN_OUT, J_PIN_OE, J_FORCE_OUT, J_FORCE_IN, J_PERIPH_DATA;
  logic [31:0]     WDATA, RDATA, rdat;
  logic [1:0][7:0] ext, ext_en, pins;
  int              mismatches, tests_run;
  dgp_pkg::dgp_ext_strobe_t EXT_STROBE;
  localparam logic [7:0] RST_V [9] = '{8'hFF, 8'h0A, 8'h00, 8'h00, 8'h00,
                                       8'hFF, 8'hB5, 8'h00, 8'h00};
  assign H_PIN_IN = pins[0];
  assign J_PIN_IN = pins[1];
  dgp_port dgp_port_inst (.*);
  dgp_board_model dgp_board_model_inst (
    .out    ({J_PIN_OUT, H_PIN_OUT}),
    .oe     ({J_PIN_OE, H_PIN_OE}),
    .ext    (ext),
    .ext_en (ext_en),
    .clk    (CORE_CLK),
    .pin    (pins)
  );
  always #2.5 CORE_CLK = ~CORE_CLK;
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] jmap(input logic [6:0] s);
    return {s[6:5], 1'b0, s[4:0]};
  endfunction
  task automatic chk(input string n, input logic [39:0] s, input logic [39:0] e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic settle();
    repeat (3) @(posedge CORE_CLK);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CORE_CLK);
    AWADDR <= a;
    WDATA <= {24'h0, d};
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge CORE_CLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (!BVALID);
    rsp = BRESP;
    BREADY <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge CORE_CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge CORE_CLK);
      if (ARREADY) ARVALID <= 1'b0;
    end while (!RVALID);
    rdat = RDATA;
    rsp = RRESP;
    RREADY <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk($sformatf("reg_%h", a), {rsp, rdat}, {2'h0, 24'h0, e});
  endtask
  task automatic summarize();
    if (mismatches == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge CORE_CLK);
    mismatches++;
    summarize();
  end
  initial begin
    CORE_CLK = 1'b0;
    RESET_N = 1'b0;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY, PSP_MODE} = 6'h00;
    {AWPROT, ARPROT, AWADDR, ARADDR, WDATA} = '0;
    {PWM_OUT, PWM_EN, J_FORCE_OUT, J_FORCE_IN, J_PERIPH_DATA} = '0;
    WSTRB = 4'hF;
    EXT_ADDR_HIGH_BITS = 4'hA;
    EXT_STROBE = 7'h55;
    ext = 16'h20F0;
    ext_en = 16'h20F0;
    mismatches = 0;
    tests_run = 0;
    repeat (12) @(posedge CORE_CLK);
    RESET_N <= 1'b1;
    settle();
    chk("h_oe", H_PIN_OE, 8'h0F);
    chk("h_addr", H_PIN_OUT[3:0], 4'hA);
    chk("j_oe", J_PIN_OE, 8'hDF);
    chk("j_strobe", J_PIN_OUT & 8'hDF, jmap(7'h55));
    chk("ttl", H_LO_TTL_SEL, 1'b1);
    for (int i = 0; i < 9; i++) rchk(8'(4 * i), RST_V[i]);
    wr(`DGP_OFS_MEM_CFG, 8'hFF);
    rchk(`DGP_OFS_MEM_CFG, 8'hB3);
    chk("mem", {EXT_BUS_EN, EXT_WAIT_CFG, EXT_WRITE_MODE}, 5'h0F);
    wr(`DGP_OFS_ANA_CFG, 8'hFF);
    rchk(`DGP_OFS_ANA_CFG, 8'h3F);
    chk("ana", {ANALOG_VREF_CFG, ANALOG_CHAN_SEL}, 6'h30);
    @(posedge CORE_CLK);
    ext[0] <= 8'h03;
    ext_en[0] <= 8'h0F;
    wr(`DGP_OFS_H_LAT, 8'h5A);
    wr(`DGP_OFS_H_DIR, 8'h0F);
    settle();
    chk("h_oe", H_PIN_OE, 8'hF0);
    chk("h_out", H_PIN_OUT[7:4], 4'h5);
    chk("ttl", H_LO_TTL_SEL, 1'b0);
    rchk(`DGP_OFS_H_LAT, 8'h5A);
    rchk(`DGP_OFS_H_PIN, 8'h53);
    wr(`DGP_OFS_H_PIN, 8'hA5);
    rchk(`DGP_OFS_H_LAT, 8'hA5);
    @(posedge CORE_CLK);
    PSP_MODE <= 1'b1;
    wr(`DGP_OFS_ANA_CFG, 8'h02);
    settle();
    chk("ttl", H_LO_TTL_SEL, 1'b1);
    chk("chan", ANALOG_CHAN_SEL, 4'h3);
    chk("h_oe", H_PIN_OE, 8'hC0);
    rchk(`DGP_OFS_H_PIN, 8'h83);
    @(posedge CORE_CLK);
    PWM_EN <= 4'h1;
    PWM_OUT <= 4'h1;
    settle();
    chk("pwm", {H_PIN_OUT[4], H_PIN_OE}, 9'h1D0);
    wr(`DGP_OFS_PWM_MAP, 8'h01);
    settle();
    chk("remap", {PWM_PIN_REMAP, H_PIN_OE}, 9'h1C0);
    @(posedge CORE_CLK);
    ext[1] <= 8'hA0;
    ext_en[1] <= 8'hF0;
    wr(`DGP_OFS_J_LAT, 8'h3C);
    wr(`DGP_OFS_J_DIR, 8'hF0);
    settle();
    chk("j_io", {J_PIN_OUT[3:0], J_PIN_OE}, 12'hC0F);
    rchk(`DGP_OFS_J_LAT, 8'h3C);
    rchk(`DGP_OFS_J_PIN, 8'hAC);
    @(posedge CORE_CLK);
    ext_en <= 16'h0000;
    J_FORCE_OUT <= 8'hA0;
    J_PERIPH_DATA <= 8'h80;
    J_FORCE_IN <= 8'h01;
    settle();
    chk("j_force", J_PIN_OE, 8'hAE);
    chk("j_fdat", {J_PIN_OUT[7], J_PIN_OUT[5]}, 2'h2);
    rchk(`DGP_OFS_J_DIR, 8'hF0);
    @(posedge CORE_CLK);
    J_FORCE_OUT <= 8'h00;
    J_FORCE_IN <= 8'h20;
    wr(`DGP_OFS_J_DIR, 8'h00);
    wr(`DGP_OFS_MEM_CFG, 8'h00);
    settle();
    chk("j_bus", {J_PIN_OE, J_PIN_OUT & 8'hDF}, {8'hDF, jmap(7'h55)});
    chk("h_bus", {H_PIN_OE[3:0], H_PIN_OUT[3:0]}, 8'hFA);
    WSTRB <= 4'h0;
    wr(`DGP_OFS_J_LAT, 8'hFF);
    WSTRB <= 4'hF;
    rchk(`DGP_OFS_J_LAT, 8'h3C);
    wr(8'h24, 8'h11);
    chk("wr_err", rsp, 2'h2);
    rd(8'h24);
    chk("rd_err", {rsp, rdat}, {2'h2, 32'h0});
    wr(`DGP_OFS_MEM_CFG, 8'h80);
    @(posedge CORE_CLK);
    RESET_N <= 1'b0;
    repeat (12) @(posedge CORE_CLK);
    RESET_N <= 1'b1;
    rchk(`DGP_OFS_MEM_CFG, 8'h00);
    rchk(`DGP_OFS_J_DIR, 8'hFF);
    summarize();
  end
endmodule
